// ### shared/belt_mon_pkg.sv
// Contract
// [RL1] After a stop trip, restart waits 60 s / starts-per-minute limit.
// [RL2] Start opens a 1..15 s grace period (default 5) with countdown.
// [RL3] Acceleration, bearing heat and plug checks stay live in grace.
// [RL4] Nonzero acceleration level stops the belt when start-up speed lags.
// [RL5] Under-speed when speed is 1..10 % (default 10) below calibrated.
// [RL6] Severe under-speed, 1..20 % (default 20), drops stop relay at once.
// [RL7] Over-speed when speed is 1..10 % (default 10) above calibrated.
// [RL8] Severe over-speed, 1..20 % (default 20), stops at once without delay.
// [RL9] Per-condition alarm delay 0..10 s counts down, back up when clear.
// [RL10] Under-speed alarm delay at zero: alarm relay off, amber lamp, event.
// [RL11] Stop delay 0..60 s (default 60) runs alongside the alarm delay.
// [RL12] Under-speed stop delay at zero: stop relay off, red lamp, event.
// [RL13] Over-speed has own alarm and stop delays, same relays and lamps.
// [RL14] Head pair modes: off, pulse, contact (default) or rub block.
// [RL15] Pulse mode alarms when smaller count is under 66 % of the larger.
// [RL16] Contact mode: low input misaligned; inversion is factory only (here ctrl bit 13, writable over the bus).
// [RL17] Rub block alarms above an absolute limit, default 140 degrees.
// [RL18] Rub reference: off, ambient one, ambient two or opposite sensor.
// [RL19] Alarm when block exceeds the reference by margin (default 30).
// [RL20] Temp_slope_limit needs a reference, default 3.0 deg/min, alarm only.
// [RL21] Head alignment: own alarm delay (default 1), stop delay (default 60).
// [RL22] One-second tick drives all delays; relays energized when fault-free.
package belt_mon_pkg;
	localparam int          CLK_HZ        = 100_000_000;
	localparam int          TICK_PERIOD_S = 1;
	localparam int          TICK_CYCLES   = TICK_PERIOD_S * CLK_HZ;
	localparam logic [7:0]  JOG_BASE_S    = 8'h3c;
	// Register byte offsets
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_SPEED     = 8'h04;
	localparam logic [7:0]  OFS_SPD_DLY   = 8'h08;
	localparam logic [7:0]  OFS_ALIGN     = 8'h0c;
	localparam logic [7:0]  OFS_ALN_DLY   = 8'h10;
	localparam logic [7:0]  OFS_STATUS    = 8'h14;
	// Reset values
	localparam logic [31:0] RST_CTRL      = 32'h0000_0553;
	localparam logic [31:0] RST_SPEED     = 32'h140a_140a;
	localparam logic [31:0] RST_SPD_DLY   = 32'h3c01_3c01;
	localparam logic [31:0] RST_ALIGN     = 32'h1e1e_8c12;
	localparam logic [31:0] RST_ALN_DLY   = 32'h0000_3c01;
	// Control fields
	localparam int          F_RATE        = 0;
	localparam int          F_ACCEL       = 4;
	localparam int          F_GRACE       = 8;
	localparam int          F_CLEAR       = 12;
	localparam int          F_INVERT      = 13;
	// Speed fields
	localparam int          F_UNDER       = 0;
	localparam int          F_SEV_UNDER   = 8;
	localparam int          F_OVER        = 16;
	localparam int          F_SEV_OVER    = 24;
	// Delay fields: two alarm/stop pairs in the speed word, only the first pair used in the alignment word
	localparam int          F_ADLY0       = 0;
	localparam int          F_SDLY0       = 8;
	localparam int          F_ADLY1       = 16;
	localparam int          F_SDLY1       = 24;
	// Alignment fields
	localparam int          F_MODE        = 0;
	localparam int          F_REF         = 2;
	localparam int          F_ROR_EN      = 4;
	localparam int          F_ABS         = 8;
	localparam int          F_MARGIN      = 16;
	localparam int          F_SLOPE       = 24;
	localparam int          PULSE_PCT     = 66;
	localparam int          MIN_PER_SLOPE = 60;
	// Fault source bits
	localparam int          SRC_U_ALM     = 0;
	localparam int          SRC_U_STP     = 1;
	localparam int          SRC_U_SEV     = 2;
	localparam int          SRC_O_ALM     = 3;
	localparam int          SRC_O_STP     = 4;
	localparam int          SRC_O_SEV     = 5;
	localparam int          SRC_ACCEL     = 6;
	localparam int          SRC_A_ALM     = 7;
	localparam int          SRC_A_STP     = 8;
	localparam int          SRC_ROR       = 9;
	localparam int          SRC_BEARING   = 10;
	localparam int          SRC_PLUG      = 11;
	localparam int          NSRC          = 12;
	localparam logic [11:0] STOP_SRCS     = 12'h176;

	typedef enum logic [1:0] {
		PAIR_OFF     = 2'h0,
		PAIR_PULSE   = 2'h1,
		PAIR_CONTACT = 2'h2,
		PAIR_RUB     = 2'h3
	} pair_mode_e;

	typedef enum logic [1:0] {
		REF_OFF  = 2'h0,
		REF_AMBIENT_REF_ONE = 2'h1,
		REF_AMBIENT_REF_TWO = 2'h2,
		REF_OPP  = 2'h3
	} ref_sel_e;
endpackage : belt_mon_pkg

// ### core/belt_speed_align_monitor.sv
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/10ps
module belt_speed_align_monitor
	import belt_mon_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Wishbone classic slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Motor control
	input  wire logic        start_req,
	input  wire logic        stop_req,
	output logic             running,
	output logic             restart_blocked,
	output logic             grace_active,
	// Speed, per-second sample
	input  wire logic [15:0] speed_meas,
	input  wire logic [15:0] speed_cal,
	// Always-live checks
	input  wire logic        bearing_hot,
	input  wire logic        plug_detect,
	// Head pair sensors
	input  wire logic        pulse_left,
	input  wire logic        pulse_right,
	input  wire logic        contact_left,
	input  wire logic        contact_right,
	input  wire logic [7:0]  temp_left,
	input  wire logic [7:0]  temp_right,
	input  wire logic [7:0]  ambient_ref_one,
	input  wire logic [7:0]  ambient_ref_two,
	// Relays, lamps and event log
	output logic             alarm_relay,
	output logic             stop_relay,
	output logic             alarm_led,
	output logic             stop_led,
	output logic             event_valid,
	output logic             event_stop,
	output logic      [3:0]  event_source
);
	if (TICK_LEN < 2) begin : g_chk
		$error("TICK_LEN must be at least 2");
	end

	function automatic logic [31:0] wr_mask(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : wr_mask

	function automatic logic [3:0] first_set(input logic [NSRC-1:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction : first_set

	// Whole-second integer division of 60 by the rate; 60/7 etc. round down
	function automatic logic [5:0] jog_secs(input logic [3:0] rate);
		logic [3:0] r;
		r = (rate == 4'h0) ? 4'h1 : rate;
		return 6'(JOG_BASE_S / 8'(r));
	endfunction : jog_secs

	// Register file
	logic [31:0] ctrl, spd, spd_dly, aln, aln_dly;
	wire         bus_req  = cyc_i & stb_i & ~ack_o;
	wire         bus_wr   = bus_req & we_i;
	wire         clr_hit  = bus_wr & (adr_i == OFS_CTRL) & sel_i[1]
	                        & dat_i[F_CLEAR];
	logic [NSRC-1:0] fault;
	logic [5:0]      jog_cnt;
	logic [3:0]      grace_cnt;
	wire  [31:0] status   = {4'h0, fault, stop_led, alarm_led,
	                         grace_active, running, grace_cnt, 2'h0, jog_cnt};
	wire  [31:0] rd_mux   =
		(adr_i == OFS_CTRL)    ? ctrl :
		(adr_i == OFS_SPEED)   ? spd :
		(adr_i == OFS_SPD_DLY) ? spd_dly :
		(adr_i == OFS_ALIGN)   ? aln :
		(adr_i == OFS_ALN_DLY) ? aln_dly :
		(adr_i == OFS_STATUS)  ? status : 32'h0000_0000;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl    <= RST_CTRL;
			spd     <= RST_SPEED;
			spd_dly <= RST_SPD_DLY;
			aln     <= RST_ALIGN;
			aln_dly <= RST_ALN_DLY;
		end else if (bus_wr) begin
			// Clear bit is a command, never stored
			if (adr_i == OFS_CTRL) begin
				ctrl <= wr_mask(ctrl, dat_i, sel_i) & ~(32'h1 << F_CLEAR);
			end
			if (adr_i == OFS_SPEED) begin
				spd <= wr_mask(spd, dat_i, sel_i);
			end
			if (adr_i == OFS_SPD_DLY) begin
				spd_dly <= wr_mask(spd_dly, dat_i, sel_i);
			end
			if (adr_i == OFS_ALIGN) begin
				aln <= wr_mask(aln, dat_i, sel_i);
			end
			if (adr_i == OFS_ALN_DLY) begin
				aln_dly <= wr_mask(aln_dly, dat_i, sel_i);
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= bus_req;
			dat_o <= bus_req ? rd_mux : 32'h0000_0000;
		end
	end

	// One-second time base
	logic [31:0] tick_div;
	wire         tick = (tick_div == 32'(TICK_LEN - 1));
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tick_div <= 32'h0;
		end else begin
			tick_div <= tick ? 32'h0 : tick_div + 32'h1; // [RL22]
		end
	end

	// Config fields
	wire [3:0] rate_lim   = ctrl[F_RATE +: 4];
	wire [3:0] accel_lvl  = ctrl[F_ACCEL +: 4];
	wire [3:0] grace_pre  = ctrl[F_GRACE +: 4];
	wire       invert     = ctrl[F_INVERT];
	wire [6:0] under_pct  = {3'h0, spd[F_UNDER +: 4]};
	wire [6:0] sev_u_pct  = {2'h0, spd[F_SEV_UNDER +: 5]};
	wire [6:0] over_pct   = {3'h0, spd[F_OVER +: 4]};
	wire [6:0] sev_o_pct  = {2'h0, spd[F_SEV_OVER +: 5]};
	pair_mode_e top_pair_mode;
	ref_sel_e   ref_sel;
	assign top_pair_mode  = pair_mode_e'(aln[F_MODE +: 2]);
	assign ref_sel        = ref_sel_e'(aln[F_REF +: 2]);
	wire       ror_en     = aln[F_ROR_EN];
	wire [7:0] abs_lim    = aln[F_ABS +: 8];
	wire [7:0] margin     = aln[F_MARGIN +: 8];
	wire [7:0] temp_slope_limit = aln[F_SLOPE +: 8];

	// Run state, restart spacing and grace countdown
	wire stop_trip   = |(fault & STOP_SRCS);
	wire start_ok    = start_req & ~running & (jog_cnt == 6'h0);
	wire mon_active  = running & ~grace_active;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			running         <= 1'b0;
			jog_cnt         <= 6'h0;
			grace_cnt       <= 4'h0;
			grace_active    <= 1'b0;
			restart_blocked <= 1'b0;
		end else begin
			if (running & stop_trip) begin
				running <= 1'b0;
				jog_cnt <= jog_secs(rate_lim); // [RL1]
			end else if (running & stop_req) begin
				running <= 1'b0;
			end else if (start_ok) begin
				running <= 1'b1;
			end else if (tick && jog_cnt != 6'h0) begin
				jog_cnt <= jog_cnt - 6'h1; // [RL1]
			end
			if (start_ok) begin
				grace_cnt <= grace_pre; // [RL2]
			end else if (!running || stop_trip) begin
				grace_cnt <= 4'h0;
			end else if (tick && grace_cnt != 4'h0) begin
				grace_cnt <= grace_cnt - 4'h1; // [RL2]
			end
			grace_active    <= start_ok | (running & ~stop_trip
			                   & ~(tick & grace_cnt == 4'h1)
			                   & grace_cnt != 4'h0);
			restart_blocked <= (running & stop_trip)
			                   | (jog_cnt > 6'h1)
			                   | (jog_cnt == 6'h1 & ~tick);
		end
	end

	// Speed comparisons scaled by 100
	wire [23:0] meas100 = 24'(speed_meas) * 24'd100;
	wire [23:0] cal_u   = 24'(speed_cal) * 24'(7'd100 - under_pct);
	wire [23:0] cal_su  = 24'(speed_cal) * 24'(7'd100 - sev_u_pct);
	wire [23:0] cal_o   = 24'(speed_cal) * 24'(7'd100 + over_pct);
	wire [23:0] cal_so  = 24'(speed_cal) * 24'(7'd100 + sev_o_pct);
	wire under_c   = mon_active & (meas100 <= cal_u);  // [RL5]
	wire sev_u_c   = mon_active & (meas100 <= cal_su); // [RL6]
	wire over_c    = mon_active & (meas100 >= cal_o);  // [RL7]
	wire sev_o_c   = mon_active & (meas100 >= cal_so); // [RL8]

	// Start-up profile: speed share must keep up with elapsed share
	wire [3:0]  elapsed  = grace_pre - grace_cnt;
	wire [31:0] acc_have = 32'(speed_meas) * 32'(grace_pre) * 32'd5;
	wire [31:0] acc_need = 32'(speed_cal) * 32'(elapsed) * 32'(accel_lvl);
	wire accel_c  = grace_active & running & tick & (accel_lvl != 4'h0)
	                & (acc_have < acc_need); // [RL3] [RL4]

	// Pulse pair counted over one second
	logic        pl_q, pr_q, pulse_bad;
	logic [15:0] cnt_l, cnt_r;
	wire  [15:0] c_max = (cnt_l > cnt_r) ? cnt_l : cnt_r;
	wire  [15:0] c_min = (cnt_l > cnt_r) ? cnt_r : cnt_l;
	wire         pulse_ratio_low = (24'(c_min) * 24'd100)
	                               < (24'(c_max) * 24'(PULSE_PCT)); // [RL15]
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pl_q      <= 1'b0;
			pr_q      <= 1'b0;
			cnt_l     <= 16'h0;
			cnt_r     <= 16'h0;
			pulse_bad <= 1'b0;
		end else begin
			pl_q  <= pulse_left;
			pr_q  <= pulse_right;
			if (tick) begin
				pulse_bad <= pulse_ratio_low;
				cnt_l     <= 16'h0;
				cnt_r     <= 16'h0;
			end else begin
				if (pulse_left & ~pl_q & ~&cnt_l) cnt_l <= cnt_l + 16'h1;
				if (pulse_right & ~pr_q & ~&cnt_r) cnt_r <= cnt_r + 16'h1;
			end
		end
	end

	// Contact and rub block
	wire contact_bad = (contact_left == invert)
	                   | (contact_right == invert); // [RL16]
	wire [7:0] ref_l = (ref_sel == REF_AMBIENT_REF_ONE) ? ambient_ref_one :
	                   (ref_sel == REF_AMBIENT_REF_TWO) ? ambient_ref_two : temp_right;
	wire [7:0] ref_r = (ref_sel == REF_AMBIENT_REF_ONE) ? ambient_ref_one :
	                   (ref_sel == REF_AMBIENT_REF_TWO) ? ambient_ref_two : temp_left;
	wire abs_bad = (temp_left > abs_lim) | (temp_right > abs_lim); // [RL17]
	wire rel_bad = (ref_sel != REF_OFF)                            // [RL18]
	               & ((9'(temp_left) > 9'(ref_l) + 9'(margin))
	               | (9'(temp_right) > 9'(ref_r) + 9'(margin))); // [RL19]
	wire rub_bad = abs_bad | rel_bad;
	wire align_c = mon_active & (                                  // [RL14]
		(top_pair_mode == PAIR_PULSE   & pulse_bad) |
		(top_pair_mode == PAIR_CONTACT & contact_bad) |
		(top_pair_mode == PAIR_RUB     & rub_bad));

	// Temp_slope_limit sampled once a minute, slope in tenths of a degree
	logic [5:0]  min_cnt;
	logic [7:0]  prev_l, prev_r;
	logic        ror_hit;
	wire  [11:0] rise_l  = (temp_left > prev_l)
	                       ? 12'(temp_left - prev_l) * 12'd10 : 12'h0;
	wire  [11:0] rise_r  = (temp_right > prev_r)
	                       ? 12'(temp_right - prev_r) * 12'd10 : 12'h0;
	wire         ror_arm = running & (top_pair_mode == PAIR_RUB)
	                       & (ref_sel != REF_OFF) & ror_en; // [RL20]
	wire         min_end = tick & (min_cnt == 6'(MIN_PER_SLOPE - 1));
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			min_cnt <= 6'h0;
			prev_l  <= 8'h0;
			prev_r  <= 8'h0;
			ror_hit <= 1'b0;
		end else begin
			if (tick) begin
				min_cnt <= min_end ? 6'h0 : min_cnt + 6'h1;
			end
			if (min_end) begin
				prev_l  <= temp_left;
				prev_r  <= temp_right;
			end
			ror_hit <= min_end & ror_arm
			           & ((rise_l >= 12'(temp_slope_limit))
			           | (rise_r >= 12'(temp_slope_limit))); // [RL20]
		end
	end

	// Cumulative alarm/stop delay pairs: 0 under, 1 over, 2 head align
	wire [2:0] cond  = {align_c, over_c, under_c};
	wire [3:0] a_pre [3];
	wire [5:0] s_pre [3];
	assign a_pre[0] = spd_dly[F_ADLY0 +: 4];
	assign s_pre[0] = spd_dly[F_SDLY0 +: 6];
	assign a_pre[1] = spd_dly[F_ADLY1 +: 4];
	assign s_pre[1] = spd_dly[F_SDLY1 +: 6];
	assign a_pre[2] = aln_dly[F_ADLY0 +: 4]; // [RL21]
	assign s_pre[2] = aln_dly[F_SDLY0 +: 6]; // [RL21]
	logic [2:0] a_hit, s_hit;

	for (genvar g = 0; g < 3; g++) begin : g_dly
		logic [3:0] a_cnt;
		logic [5:0] s_cnt;
		assign a_hit[g] = cond[g] & (a_cnt == 4'h0); // [RL10] [RL13]
		assign s_hit[g] = cond[g] & (s_cnt == 6'h0); // [RL12] [RL13]
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				a_cnt <= RST_SPD_DLY[3:0];
				s_cnt <= RST_SPD_DLY[13:8];
			end else begin
				if (a_cnt > a_pre[g] || !running) begin
					a_cnt <= a_pre[g];
				end else if (tick && cond[g] && a_cnt != 4'h0) begin
					a_cnt <= a_cnt - 4'h1; // [RL9]
				end else if (tick && !cond[g] && a_cnt < a_pre[g]) begin
					a_cnt <= a_cnt + 4'h1; // [RL9]
				end
				if (s_cnt > s_pre[g] || !running) begin
					s_cnt <= s_pre[g];
				end else if (tick && cond[g] && s_cnt != 6'h0) begin
					s_cnt <= s_cnt - 6'h1; // [RL11]
				end else if (tick && !cond[g] && s_cnt < s_pre[g]) begin
					s_cnt <= s_cnt + 6'h1; // [RL11]
				end
			end
		end
	end

	// Fault latches: a new trip wins over a same-cycle clear
	logic [NSRC-1:0] trip;
	always_comb begin
		trip              = '0;
		trip[SRC_U_ALM]   = a_hit[0];
		trip[SRC_U_STP]   = s_hit[0];
		trip[SRC_U_SEV]   = sev_u_c;    // [RL6]
		trip[SRC_O_ALM]   = a_hit[1];
		trip[SRC_O_STP]   = s_hit[1];
		trip[SRC_O_SEV]   = sev_o_c;    // [RL8]
		trip[SRC_ACCEL]   = accel_c;
		trip[SRC_A_ALM]   = a_hit[2];
		trip[SRC_A_STP]   = s_hit[2];
		trip[SRC_ROR]     = ror_hit;
		trip[SRC_BEARING] = bearing_hot; // [RL3]
		trip[SRC_PLUG]    = plug_detect; // [RL3]
	end
	wire [NSRC-1:0] fresh      = trip & ~fault;
	wire [NSRC-1:0] next_fault = (fault & ~{NSRC{clr_hit | start_ok}})
	                             | trip;
	wire            next_stop  = |(next_fault & STOP_SRCS);
	wire            next_alarm = |(next_fault & ~STOP_SRCS);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fault        <= '0;
			alarm_relay  <= 1'b1;
			stop_relay   <= 1'b1;
			alarm_led    <= 1'b0;
			stop_led     <= 1'b0;
			event_valid  <= 1'b0;
			event_stop   <= 1'b0;
			event_source <= 4'h0;
		end else begin
			fault        <= next_fault;
			alarm_relay  <= ~next_alarm; // [RL10] [RL20] [RL22]
			stop_relay   <= ~next_stop;  // [RL12] [RL22]
			alarm_led    <= next_alarm;
			stop_led     <= next_stop;
			event_valid  <= |fresh;      // [RL10] [RL12]
			event_stop   <= |(fresh & STOP_SRCS & ~(fresh - 12'h1));
			event_source <= first_set(fresh);
		end
	end
endmodule : belt_speed_align_monitor

// ### bench/belt_mon_asserts.sv
`timescale 1ns/10ps
module belt_mon_asserts
	import belt_mon_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
) (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst,
	// Bus
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	// Motor
	input wire logic        start_req,
	input wire logic        running,
	input wire logic        restart_blocked,
	input wire logic        grace_active,
	// Field outputs
	input wire logic        alarm_relay,
	input wire logic        stop_relay,
	input wire logic        alarm_led,
	input wire logic        stop_led,
	input wire logic        event_valid
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_start;
		start_req && !running && !restart_blocked;
	endsequence

	a_ack_next: assert property (s_req |=> ack_o)
		else $error("request not answered next cycle");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data not zero outside ack");
	a_start_taken: assert property (
		s_start |=> running && grace_active)
		else $error("accepted start did not run with grace");
	a_run_cause: assert property (
		$rose(running) |-> $past(start_req) && grace_active)
		else $error("run began without a start");
	a_jog_holds: assert property (
		restart_blocked |-> !running)
		else $error("running while restart spacing active");
	a_alarm_lamp: assert property (
		alarm_led == !alarm_relay)
		else $error("alarm lamp and alarm relay disagree");
	a_stop_lamp: assert property (
		stop_led == !stop_relay)
		else $error("stop lamp and stop relay disagree");
	a_alarm_logged: assert property (
		$fell(alarm_relay) |-> event_valid)
		else $error("alarm relay dropped without event");
	a_stop_logged: assert property (
		$fell(stop_relay) |-> event_valid ##[0:1] !running)
		else $error("stop without event or motor kept running");
	a_stop_spacing: assert property (
		$fell(stop_relay) |-> ##[0:2] restart_blocked)
		else $error("stop trip did not block restart");
endmodule : belt_mon_asserts

// ### bench/belt_field_model.sv
`timescale 1ns/10ps
module belt_field_model #(
	parameter logic [15:0] CAL = 16'h03e8
) (
	// Clock and motor state
	input  wire logic        clock,
	input  wire logic        running,
	input  wire logic        stop_relay,
	// Scenario controls
	input  wire logic [7:0]  pct,
	input  wire logic        mis,
	// Sensors
	output logic      [15:0] speed_meas,
	output logic      [15:0] speed_cal,
	output logic             pulse_left,
	output logic             pulse_right,
	output logic             contact_left,
	output logic             contact_right,
	output logic      [7:0]  temp_left,
	output logic      [7:0]  temp_right,
	output logic      [7:0]  ambient_ref_one,
	output logic      [7:0]  ambient_ref_two
);
	logic [3:0] beat = 4'h0;
	logic       turning;

	// Belt speed drops to zero at once when the run or stop relay lets go
	assign turning = running && stop_relay;
	assign speed_cal = CAL;
	assign speed_meas = turning ? 16'((32'(CAL) * pct) / 100) : 16'h0;
	assign pulse_left = turning && beat[3];
	assign pulse_right = turning && beat[3];
	// High means aligned; a drifting belt opens the left contact
	assign contact_left = !mis;
	assign contact_right = 1'b1;
	assign temp_left = 8'h28;
	assign temp_right = 8'h28;
	assign ambient_ref_one = 8'h1e;
	assign ambient_ref_two = 8'h1e;

	always_ff @(posedge clock) beat <= beat + 4'h1;
endmodule : belt_field_model

// ### bench/test_belt_speed_align_monitor.sv
`timescale 1ns/10ps
module test_belt_speed_align_monitor;
	import belt_mon_pkg::*;
	localparam int T = 20;
	localparam int AR = 0;
	localparam int SR = 1;
	localparam int GR = 2;
	localparam int BL = 3;
	logic        clock, rst, cyc_i, stb_i, we_i, ack_o;
	logic [7:0]  adr_i, pct, temp_left, temp_right;
	logic [7:0]  ambient_ref_one, ambient_ref_two;
	logic [3:0]  sel_i, event_source;
	logic [31:0] dat_i, dat_o, q;
	logic [15:0] speed_meas, speed_cal;
	logic        start_req, stop_req, running, restart_blocked;
	logic        grace_active, bearing_hot, plug_detect, mis;
	logic        pulse_left, pulse_right, contact_left, contact_right;
	logic        alarm_relay, stop_relay, alarm_led, stop_led;
	logic        event_valid, event_stop;
	int          num_errors = 0;
	int          n_checks = 0;
	int          n;

	belt_speed_align_monitor #(.TICK_LEN(T)) dut_u (.clock, .rst,
		.cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.start_req, .stop_req, .running, .restart_blocked, .grace_active,
		.speed_meas, .speed_cal, .bearing_hot, .plug_detect, .pulse_left,
		.pulse_right, .contact_left, .contact_right, .temp_left,
		.temp_right, .ambient_ref_one, .ambient_ref_two, .alarm_relay,
		.stop_relay, .alarm_led, .stop_led, .event_valid, .event_stop,
		.event_source);
	belt_field_model fm_u (.clock, .running, .stop_relay, .pct, .mis,
		.speed_meas, .speed_cal, .pulse_left, .pulse_right, .contact_left,
		.contact_right, .temp_left, .temp_right, .ambient_ref_one,
		.ambient_ref_two);

	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, s);
			num_errors++;
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (ack_o !== 1'b1 && k < 20);
		chk("bus ack", 32'h1, 32'(ack_o));
		if (ack_o !== 1'b1)
			stop_test;
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clock);
	endtask : wb

	function automatic logic pick(input int s);
		case (s)
			AR: return alarm_relay;
			SR: return stop_relay;
			GR: return grace_active;
			default: return restart_blocked;
		endcase
	endfunction : pick

	// Bounded wait; n keeps the cycles spent
	task automatic waitv(input int s, input logic v, input int lim);
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pick(s) !== v && n < lim);
		if (pick(s) !== v) begin
			$display("wrong value wait %0d expected %b seen %b", s, v, pick(s));
			num_errors++;
			stop_test;
		end
	endtask : waitv

	task automatic hold(input int s, input logic v, input int span);
		int bad;
		bad = 0;
		repeat (span) begin
			@(posedge clock);
			if (pick(s) !== v)
				bad++;
		end
		chk("held level", 32'h0, 32'(bad));
	endtask : hold

	task automatic press(input logic go);
		if (go)
			start_req <= 1'b1;
		else
			stop_req <= 1'b1;
		@(posedge clock);
		start_req <= 1'b0;
		stop_req <= 1'b0;
		@(posedge clock);
	endtask : press

	task automatic t_regs;
		logic [7:0]  ofs [6];
		logic [31:0] rv [6];
		ofs = '{OFS_CTRL, OFS_SPEED, OFS_SPD_DLY, OFS_ALIGN, OFS_ALN_DLY,
			8'h20};
		rv = '{RST_CTRL, RST_SPEED, RST_SPD_DLY, RST_ALIGN, RST_ALN_DLY,
			32'h0};
		for (int i = 0; i < 6; i++) begin
			wb(1'b0, ofs[i], 32'h0);
			chk("register", rv[i], q);
		end
		wb(1'b1, OFS_STATUS, 32'hffff_ffff);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk("status", 32'h0, q);
	endtask : t_regs

	task automatic t_grace;
		int n1;
		wb(1'b1, OFS_CTRL, 32'h0000_0203);
		press(1'b1);
		chk("running", 32'h1, 32'(running));
		chk("grace", 32'h1, 32'(grace_active));
		bearing_hot <= 1'b1;
		waitv(AR, 1'b0, 4);
		n1 = n;
		chk("source", 32'(SRC_BEARING), 32'(event_source));
		bearing_hot <= 1'b0;
		waitv(GR, 1'b0, 2 * T + 4);
		chk("grace span", 32'h1, 32'(n1 + n >= T - 1));
		wb(1'b1, OFS_CTRL, 32'h0000_1203);
		chk("relay back", 32'h1, 32'(alarm_relay));
	endtask : t_grace

	// 91, 90 and 110 percent of calibrated speed
	task automatic t_speed;
		logic [7:0] pv [3];
		logic [3:0] sv [3];
		pv = '{8'h5b, 8'h5a, 8'h6e};
		sv = '{4'h0, 4'(SRC_U_ALM), 4'(SRC_O_ALM)};
		for (int i = 0; i < 3; i++) begin
			pct <= pv[i];
			if (i == 0) begin
				hold(AR, 1'b1, 3 * T);
			end else begin
				waitv(AR, 1'b0, 2 * T + 4);
				chk("source", 32'(sv[i]), 32'(event_source));
				chk("event", 32'h1, 32'(event_valid));
				chk("stop relay", 32'h1, 32'(stop_relay));
			end
			pct <= 8'h64;
			repeat (2 * T) @(posedge clock);
			wb(1'b1, OFS_CTRL, 32'h0000_1203);
		end
	endtask : t_speed

	task automatic t_align;
		mis <= 1'b1;
		waitv(AR, 1'b0, 2 * T + 4);
		chk("source", 32'(SRC_A_ALM), 32'(event_source));
		wb(1'b1, OFS_ALIGN, RST_ALIGN & 32'hffff_fffc);
		wb(1'b1, OFS_CTRL, 32'h0000_1203);
		hold(AR, 1'b1, 3 * T);
		mis <= 1'b0;
		wb(1'b1, OFS_ALIGN, 32'h1e1e_2013);
		waitv(AR, 1'b0, 2 * T + 4);
		wb(1'b1, OFS_ALIGN, RST_ALIGN);
		wb(1'b1, OFS_CTRL, 32'h0000_1203);
	endtask : t_align

	task automatic t_severe;
		pct <= 8'h50;
		waitv(SR, 1'b0, 4);
		waitv(BL, 1'b1, 3);
		chk("running", 32'h0, 32'(running));
		press(1'b1);
		chk("refused", 32'h0, 32'(running));
		pct <= 8'h64;
		waitv(BL, 1'b0, 21 * T);
		chk("jog span", 32'h1, 32'(n >= 18 * T));
	endtask : t_severe

	task automatic t_accel;
		wb(1'b1, OFS_CTRL, 32'h0000_0253);
		press(1'b1);
		chk("restart", 32'h1, 32'(running));
		hold(SR, 1'b1, 3 * T);
		press(1'b0);
		chk("stopped", 32'h0, 32'(running));
		chk("no jog", 32'h0, 32'(restart_blocked));
		pct <= 8'h00;
		press(1'b1);
		waitv(SR, 1'b0, 2 * T + 4);
		chk("source", 32'(SRC_ACCEL), 32'(event_source));
	endtask : t_accel

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial begin
		rst = 1'b1;
		{cyc_i, stb_i, we_i, start_req, stop_req} = 5'h0;
		{bearing_hot, plug_detect, mis} = 3'h0;
		adr_i = 8'h0;
		dat_i = 32'h0;
		sel_i = 4'hf;
		pct = 8'h64;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_regs;
		t_grace;
		t_speed;
		t_align;
		t_severe;
		t_accel;
		stop_test;
	end

	// A hang counts against the run
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		stop_test;
	end
endmodule : test_belt_speed_align_monitor

bind belt_speed_align_monitor belt_mon_asserts #(.TICK_LEN(TICK_LEN))
	chk_u (.clock, .rst, .cyc_i, .stb_i, .dat_o, .ack_o, .start_req,
	.running, .restart_blocked, .grace_active, .alarm_relay, .stop_relay,
	.alarm_led, .stop_led, .event_valid);
